// file: hw/mrxs_top.sv
// Purpose: receive side of the media independent port and reset straps
// Assumes: i_clk_link is the recovered receive clock (25 or 2.5 MHz)
// Notes: words cross to the link domain by a toggle handshake
//
// How it works
// - nibble goes out on four receive lines in full mode
// - reduced mode leaves receive bit two idle
// - reduced mode leaves receive bit three idle
// - bits one and two taken as mode straps
// - bit three sampled as interrupt pin select
// - select high or floating gives interrupt output
// - select low gives transmit error input, or transmit fifth bit in symbol mode
// - error flag raised for errored frame
// - symbol mode drives fifth code-group bit
// - error flag optional in reduced mode
// - valid high exactly while nibbles presented, full mode only; reduced mode keeps it low
// - receive clock out only in full mode
// - regulator enabled unless strap asks off
// - bit zero taken as lowest mode strap
// - interface choice latched once the straps have settled after reset release
`timescale 1ns/100ps
module mrxs_top (
  input wire logic i_clk_sys,                   // system clock
  input wire logic i_arst_n,                    // async reset, active low
  input wire logic i_clk_link,                  // recovered receive clock
  input wire logic i_symbol_mode,               // 5b symbol interface mode
  input wire logic i_irq_req,                   // internal interrupt request
  input wire logic i_word_valid,                // word offered by decoder
  input mrxs_pkg::mrxs_word_t i_word,           // word from decoder
  output logic o_word_ready,                    // buffer has room
  input wire logic [3:0] i_rxd_pin,             // receive data pins, in
  output logic [3:0] o_rxd_pin,                 // receive data pins, out
  output logic [3:0] o_rxd_oe,                  // receive data pins, enable
  output logic o_rx_err_pin,                    // receive error pin
  output logic o_rx_valid_pin,                  // receive valid pin
  input wire logic i_rxclk_pin,                 // receive clock pin, in
  output logic o_rxclk_pin,                     // receive clock pin, out
  output logic o_rxclk_oe,                      // receive clock pin, enable
  input wire logic i_rmii_strap_pin,            // interface select strap pin
  input wire logic i_irq_pin,                   // shared irq pin, in
  output logic o_irq_pin,                       // shared irq pin, out
  output logic o_irq_oe,                        // shared irq pin, enable
  output logic o_tx_err,                        // transmit error input
  output logic o_tx_sym4,                       // transmit fifth bit
  output logic o_reg_en,                        // core regulator enable
  output mrxs_pkg::mrxs_strap_t o_strap,        // held strap values
  output logic o_strap_done                     // straps taken
);
  import mrxs_pkg::*;

  // strap sequencer
  mrxs_st_t st_r;
  logic [3:0] cnt_r;         // settle counter
  mrxs_strap_t strap_r;      // held straps
  // pin synchronisers, first stage read only by second
  logic [3:0] rxd_s1_r, rxd_s2_r;
  logic rck_s1_r, rck_s2_r;
  logic rmii_s1_r, rmii_s2_r;
  logic irq_s1_r, irq_s2_r;
  // buffer
  mrxs_word_t buf_r [BUF_DEPTH];
  logic wp_r, rp_r;          // write and read index
  logic [1:0] cnt_buf_r;     // words held
  logic buf_full, buf_empty, buf_pop;
  // handshake, system side
  mrxs_word_t hold_r;        // word crossing to link domain
  logic req_r;               // toggles per word
  logic busy_r;              // word in flight
  logic ack_s1_r, ack_s2_r, ack_d_r;
  // link domain
  logic lrst_s1_r, lrst_n_r; // link reset, sync release
  logic req_l1_r, req_l2_r, req_ld_r;
  logic ack_r;               // toggled when word taken
  logic run_l1_r, run_l2_r;  // strap done, in link domain
  logic sym_l1_r, sym_l2_r;  // symbol mode, link domain
  logic rmii_l1_r, rmii_l2_r;
  mrxs_word_t out_r;         // word on the pins
  logic dv_r;                // nibble being presented

  // two-flop synchronisers of all pin inputs
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rxd_s1_r <= 4'h0;
      rxd_s2_r <= 4'h0;
      rck_s1_r <= 1'b0;
      rck_s2_r <= 1'b0;
      rmii_s1_r <= 1'b0;
      rmii_s2_r <= 1'b0;
      irq_s1_r <= 1'b1;
      irq_s2_r <= 1'b1;
    end else begin
      rxd_s1_r <= i_rxd_pin;
      rxd_s2_r <= rxd_s1_r;
      rck_s1_r <= i_rxclk_pin;
      rck_s2_r <= rck_s1_r;
      rmii_s1_r <= i_rmii_strap_pin;
      rmii_s2_r <= rmii_s1_r;
      irq_s1_r <= i_irq_pin;
      irq_s2_r <= irq_s1_r;
    end
  end

  // strap sequence: settle after release, take once, then run
  // pins stay released until the take, so external straps win
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= ST_SETTLE;
      cnt_r <= 4'h0;
    end else begin
      unique case (st_r)
        ST_SETTLE: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == STRAP_SETTLE_CYC - 4'h1) begin
            st_r <= ST_TAKE;
          end
        end
        ST_TAKE: begin
          st_r <= ST_RUN;
        end
        ST_RUN: begin
          st_r <= ST_RUN;
        end
      endcase
    end
  end

  // strap capture, only from synchronised pins
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      strap_r.irq_sel <= STRAP_IRQ_SEL_RST;
      strap_r.reg_dis <= STRAP_REG_DIS_RST;
      strap_r.rmii <= STRAP_RMII_RST;
      strap_r.mode <= STRAP_MODE_RST;
    end else if (st_r == ST_TAKE) begin
      strap_r.mode[0] <= rxd_s2_r[0];
      strap_r.mode[2:1] <= rxd_s2_r[2:1];
      strap_r.irq_sel <= rxd_s2_r[3];
      strap_r.reg_dis <= rck_s2_r;
      strap_r.rmii <= rmii_s2_r;
    end
  end

  // held straps go straight out; they change only at the take
  assign o_strap = strap_r;
  assign o_strap_done = (st_r == ST_RUN);
  // regulator on unless the strap asked for it off
  assign o_reg_en = !strap_r.reg_dis;

  // shared pin: open drain low for irq, else input
  // never driven high; an outside pull-up gives the idle level
  always_comb begin
    o_irq_pin = 1'b0;
    o_irq_oe = 1'b0;
    o_tx_err = 1'b0;
    o_tx_sym4 = 1'b0;
    if (st_r == ST_RUN) begin
      if (strap_r.irq_sel) begin
        o_irq_oe = i_irq_req;
      end else if (i_symbol_mode) begin
        o_tx_sym4 = irq_s2_r;
      end else begin
        o_tx_err = irq_s2_r;
      end
    end
  end

  // two-entry buffer, system side
  assign buf_full = (cnt_buf_r == 2'(BUF_DEPTH));
  assign buf_empty = (cnt_buf_r == 2'h0);
  assign o_word_ready = !buf_full;
  // one word in flight keeps hold_r still while the link side reads it
  assign buf_pop = !buf_empty && !busy_r;

  // buffer storage and pointers; a stalled link fills it
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      buf_r[0] <= '0;
      buf_r[1] <= '0;
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_buf_r <= 2'h0;
    end else begin
      if (i_word_valid && !buf_full) begin
        buf_r[wp_r] <= i_word;
        wp_r <= !wp_r;
      end
      if (buf_pop) begin
        rp_r <= !rp_r;
      end
      cnt_buf_r <= cnt_buf_r + 2'(i_word_valid && !buf_full) - 2'(buf_pop);
    end
  end

  // ack synchroniser, toggle detect on second stage only
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      ack_d_r <= 1'b0;
    end else begin
      ack_s1_r <= ack_r;
      ack_s2_r <= ack_s1_r;
      ack_d_r <= ack_s2_r;
    end
  end

  // hold register and request toggle; one word in flight
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hold_r <= '0;
      req_r <= 1'b0;
      busy_r <= 1'b0;
    end else if (buf_pop) begin
      hold_r <= buf_r[rp_r];
      req_r <= !req_r;
      busy_r <= 1'b1;
    end else if (ack_s2_r != ack_d_r) begin
      busy_r <= 1'b0;
    end
  end

  // link reset: asserts at once, releases on the link clock
  // a short reset pulse still clears this side, as the assert is asynchronous
  always_ff @(posedge i_clk_link or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lrst_s1_r <= 1'b0;
      lrst_n_r <= 1'b0;
    end else begin
      lrst_s1_r <= 1'b1;
      lrst_n_r <= lrst_s1_r;
    end
  end

  // level crossings into the link domain
  always_ff @(posedge i_clk_link or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      req_l1_r <= 1'b0;
      req_l2_r <= 1'b0;
      req_ld_r <= 1'b0;
      run_l1_r <= 1'b0;
      run_l2_r <= 1'b0;
      sym_l1_r <= 1'b0;
      sym_l2_r <= 1'b0;
      rmii_l1_r <= 1'b0;
      rmii_l2_r <= 1'b0;
    end else begin
      req_l1_r <= req_r;
      req_l2_r <= req_l1_r;
      req_ld_r <= req_l2_r;
      run_l1_r <= (st_r == ST_RUN);
      run_l2_r <= run_l1_r;
      sym_l1_r <= i_symbol_mode;
      sym_l2_r <= sym_l1_r;
      rmii_l1_r <= strap_r.rmii;
      rmii_l2_r <= rmii_l1_r;
    end
  end

  // take a word on each request toggle; hold_r is stable then
  // only the second stage is compared, so a half-seen toggle cannot lose a word
  always_ff @(posedge i_clk_link or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      out_r <= '0;
      dv_r <= 1'b0;
      ack_r <= 1'b0;
    end else if (req_l2_r != req_ld_r) begin
      out_r <= hold_r;
      dv_r <= 1'b1;
      ack_r <= !ack_r;
    end else begin
      out_r <= '0;
      dv_r <= 1'b0;
    end
  end

  // pin drive; all released until straps are held
  // reduced mode keeps the upper lines low even with their enables off
  always_comb begin
    o_rxd_pin = 4'h0;
    o_rxd_oe = 4'h0;
    o_rx_err_pin = 1'b0;
    o_rx_valid_pin = 1'b0;
    if (run_l2_r) begin
      o_rxd_pin = out_r.nib;
      if (rmii_l2_r) begin
        o_rxd_oe = 4'h3;
        o_rxd_pin[3:2] = 2'h0;
      end else begin
        o_rxd_oe = 4'hf;
        o_rx_valid_pin = dv_r;
      end
      if (sym_l2_r) begin
        o_rx_err_pin = out_r.sym4 && dv_r;
      end else begin
        o_rx_err_pin = out_r.err && dv_r;
      end
    end
  end

  // receive clock forwarded in full mode only
  assign o_rxclk_pin = i_clk_link;
  assign o_rxclk_oe = run_l2_r && !rmii_l2_r;
endmodule : mrxs_top

// file: hw/mrxs_pkg.sv
// Purpose: shared types and constants of the receive port and strap block
// Assumes: system clock of 20 MHz
// Notes: strap defaults are what a floating pin reads as
package mrxs_pkg;
  // clock period of i_clk_sys in ns
  localparam int unsigned SYS_PERIOD_NS = 50;
  // least time the strap pins settle after reset release, ns
  localparam int unsigned STRAP_SETTLE_NS = 200;
  // settle count, rounded up, never below one cycle
  localparam int unsigned STRAP_SETTLE_CYC_I =
    (STRAP_SETTLE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam logic [3:0] STRAP_SETTLE_CYC =
    4'(STRAP_SETTLE_CYC_I < 1 ? 1 : STRAP_SETTLE_CYC_I);
  // buffer depth in words
  localparam int unsigned BUF_DEPTH = 2;
  // nibble width on the receive data lines
  localparam int unsigned NIB_W = 4;
  // field positions of the word bus
  localparam int unsigned WORD_NIB_LSB = 0;
  localparam int unsigned WORD_SYM4_POS = 4;
  localparam int unsigned WORD_ERR_POS = 5;
  // reset values of the held straps (pin floating)
  localparam logic STRAP_IRQ_SEL_RST = 1'b1;
  localparam logic STRAP_REG_DIS_RST = 1'b0;
  localparam logic STRAP_RMII_RST = 1'b0;
  localparam logic [2:0] STRAP_MODE_RST = 3'h0;

  // one received nibble with its qualifiers
  typedef struct packed {
    logic err;        // error seen in the current frame
    logic sym4;       // fifth bit of an undecoded code-group
    logic [3:0] nib;  // receive nibble
  } mrxs_word_t;

  // strap values held after reset
  typedef struct packed {
    logic irq_sel;    // 1: shared pin is the interrupt output
    logic reg_dis;    // 1: internal core regulator kept off
    logic rmii;       // 1: reduced interface
    logic [2:0] mode; // default operating mode
  } mrxs_strap_t;

  // strap sequencer states
  typedef enum logic [1:0] {
    ST_SETTLE,
    ST_TAKE,
    ST_RUN
  } mrxs_st_t;
endpackage : mrxs_pkg

// file: tb/mrxs_top_sva.sv
// Purpose: checker of the receive port and strap block
// Assumes: everything is sampled on the system clock
// Notes: link-side pins are seen only at system edges, and lag the strap state
`timescale 1ns/100ps
module mrxs_top_sva (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_irq_req,
  input wire logic [3:0] o_rxd_pin,
  input wire logic [3:0] o_rxd_oe,
  input wire logic o_rx_valid_pin,
  input wire logic o_rxclk_oe,
  input wire logic o_irq_pin,
  input wire logic o_irq_oe,
  input wire logic o_tx_err,
  input wire logic o_tx_sym4,
  input wire logic o_reg_en,
  input mrxs_pkg::mrxs_strap_t o_strap,
  input wire logic o_strap_done
);
  import mrxs_pkg::*;
  // system clock and reset for all, link-side pins included
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  pins_quiet_a: assert property (!o_strap_done |-> o_rxd_oe == 4'h0 && !o_rxclk_oe)
    else $error("pins driven before straps were held");
  strap_run_a: assert property ($rose(i_arst_n) |-> !o_strap_done[*3] ##[1:6] o_strap_done)
    else $error("strap sequence length wrong");
  strap_hold_a: assert property (o_strap_done && $past(o_strap_done) |-> $stable(o_strap))
    else $error("held straps changed");
  // run reaches the pins through the link clock, so enables are judged 8 cycles on
  rmii_oe_a: assert property (o_strap_done && $past(o_strap_done, 8) && o_strap.rmii
    |-> o_rxd_oe == 4'h3)
    else $error("reduced mode enables wrong");
  rmii_hi_a: assert property (o_strap.rmii |-> o_rxd_pin[3:2] == 2'b00 && !o_rx_valid_pin)
    else $error("reduced mode drives upper lines or valid");
  mii_oe_a: assert property (o_strap_done && $past(o_strap_done, 8) && !o_strap.rmii
    |-> o_rxd_oe == 4'hf && o_rxclk_oe)
    else $error("full mode enables wrong");
  reg_en_a: assert property (o_reg_en == !o_strap.reg_dis)
    else $error("regulator enable disagrees with strap");
  irq_out_a: assert property (o_irq_oe == (o_strap_done && o_strap.irq_sel && i_irq_req) && !o_irq_pin)
    else $error("interrupt pin drive wrong");
  tx_quiet_a: assert property (o_strap.irq_sel |-> !o_tx_err && !o_tx_sym4)
    else $error("transmit error active with interrupt selected");
endmodule : mrxs_top_sva
bind mrxs_top mrxs_top_sva mrxs_top_sva_inst (.i_clk_sys, .i_arst_n, .i_irq_req, .o_rxd_pin,
  .o_rxd_oe, .o_rx_valid_pin, .o_rxclk_oe, .o_irq_pin, .o_irq_oe, .o_tx_err, .o_tx_sym4,
  .o_reg_en, .o_strap, .o_strap_done);

// file: tb/mrxs_mac_model.sv
// Purpose: controller side model that logs received nibbles
// Assumes: samples on the rising receive clock edge
// Notes: the error line is logged with each nibble and checked by the bench
`timescale 1ns/100ps
module mrxs_mac_model (
  input wire logic i_clk_link,  // receive clock
  input wire logic [3:0] i_rxd, // receive nibble
  input wire logic i_err,       // error or fifth bit
  input wire logic i_valid      // nibble qualifier
);
  logic [4:0] q[$]; // {error line, nibble}
  // one entry per qualified clock, all four lines
  // error line optional in the port, but t_stream checks it with each nibble
  // model never drives error or valid, both come straight from the port outputs
  always @(posedge i_clk_link) begin
    if (i_valid === 1'b1) begin
      q.push_back({i_err, i_rxd});
    end
  end
endmodule : mrxs_mac_model

// file: tb/mrxs_top_test.sv
// Purpose: self-checking bench of the receive port and strap block
// Assumes: link clock 125 ns, system clock 50 ns
// Notes: reset held 3 cycles; the link side clears at once, its release is synced
`timescale 1ns/100ps
module mrxs_top_test;
  import mrxs_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_clk_link = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_symbol_mode = 1'b0;
  logic i_irq_req = 1'b0;
  logic i_word_valid = 1'b0;
  mrxs_word_t i_word = '0;
  logic [3:0] pull = 4'hf; // strap resistors on data lines
  logic regulator_disable_strap_pull = 1'b0; // strap resistor on clock pin
  logic i_rmii_strap_pin = 1'b0; // interface strap resistor
  logic tx_drv = 1'b0; // controller drive of shared pin
  logic o_word_ready, o_rx_err_pin, o_rx_valid_pin, o_rxclk_pin, o_rxclk_oe;
  logic o_irq_pin, o_irq_oe, o_tx_err, o_tx_sym4, o_reg_en, o_strap_done;
  logic [3:0] o_rxd_pin, o_rxd_oe;
  mrxs_strap_t o_strap;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int stalls = 0;
  // wire levels: driver if enabled, else the resistor; shared pin takes tx_drv when select is low
  wire logic [3:0] rxd_w = (o_rxd_oe & o_rxd_pin) | (~o_rxd_oe & pull);
  wire logic clk_w = o_rxclk_oe ? o_rxclk_pin : regulator_disable_strap_pull;
  wire logic irq_w = o_irq_oe ? o_irq_pin : (o_strap.irq_sel ? 1'b1 : tx_drv);
  always #25 i_clk_sys = ~i_clk_sys;
  // link clock offset so its edges never meet the system ones
  initial begin
    #7;
    forever #62.5 i_clk_link = ~i_clk_link;
  end
  mrxs_top mrxs_top_inst (.i_clk_sys, .i_arst_n, .i_clk_link, .i_symbol_mode, .i_irq_req,
    .i_word_valid, .i_word, .o_word_ready, .i_rxd_pin(rxd_w), .o_rxd_pin, .o_rxd_oe,
    .o_rx_err_pin, .o_rx_valid_pin, .i_rxclk_pin(clk_w), .o_rxclk_pin, .o_rxclk_oe,
    .i_rmii_strap_pin, .i_irq_pin(irq_w), .o_irq_pin, .o_irq_oe, .o_tx_err, .o_tx_sym4,
    .o_reg_en, .o_strap, .o_strap_done);
  mrxs_mac_model mrxs_mac_model_inst (.i_clk_link, .i_rxd(o_rxd_pin), .i_err(o_rx_err_pin),
    .i_valid(o_rx_valid_pin));
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  // hang guard, far above the few hundred cycles needed
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      close_out();
    end
  end
  // reset with given resistors, then wait for the straps to be held
  task automatic t_straps(input logic [3:0] p, input logic rg, input logic rm);
    @(negedge i_clk_sys);
    i_arst_n = 1'b0;
    pull = p;
    regulator_disable_strap_pull = rg;
    i_rmii_strap_pin = rm;
    repeat (3) @(negedge i_clk_sys);
    i_arst_n = 1'b1;
    for (int k = 0; k < 20 && o_strap_done !== 1'b1; k++) @(negedge i_clk_sys);
    chk(o_strap === {p[3], rg, rm, p[2:0]}, "held straps");
    chk(o_reg_en === ~rg, "regulator enable");
    // the link side sees run up to two link clocks late, so wait before the pins
    repeat (8) @(negedge i_clk_sys);
    chk(o_rxd_oe === (rm ? 4'h3 : 4'hf), "data enables");
    chk(o_rxclk_oe === ~rm && o_rxclk_pin === i_clk_link, "receive clock");
  endtask : t_straps
  // offer one word, held until the buffer takes it
  task automatic send(input mrxs_word_t w);
    @(negedge i_clk_sys);
    i_word_valid = 1'b1;
    i_word = w;
    while (o_word_ready !== 1'b1) begin
      stalls++;
      @(negedge i_clk_sys);
    end
    @(posedge i_clk_sys);
  endtask : send
  // four words back to back; buffer must refuse, pins keep order
  task automatic t_stream(input logic sym);
    mrxs_word_t w;
    i_symbol_mode = sym;
    repeat (10) @(negedge i_clk_sys);
    mrxs_mac_model_inst.q.delete();
    stalls = 0;
    for (int k = 0; k < 4; k++) send(6'(k * 13 + 9));
    @(negedge i_clk_sys);
    i_word_valid = 1'b0;
    for (int k = 0; k < 80 && mrxs_mac_model_inst.q.size() < 4; k++) @(negedge i_clk_sys);
    chk(stalls > 0, "buffer never refused");
    chk(mrxs_mac_model_inst.q.size() == 4, "word count");
    for (int k = 0; k < 4 && k < mrxs_mac_model_inst.q.size(); k++) begin
      w = 6'(k * 13 + 9);
      chk(mrxs_mac_model_inst.q[k] === {sym ? w.sym4 : w.err, w.nib}, "nibble");
    end
  endtask : t_stream
  // reduced mode, shared pin as transmit error input
  task automatic t_rmii();
    t_straps(4'h5, 1'b1, 1'b1);
    mrxs_mac_model_inst.q.delete();
    send(6'h0f);
    @(negedge i_clk_sys);
    i_word_valid = 1'b0;
    tx_drv = 1'b1;
    i_symbol_mode = 1'b0;
    repeat (40) @(negedge i_clk_sys);
    chk(mrxs_mac_model_inst.q.size() == 0, "valid used in reduced mode");
    chk(o_tx_err === 1'b1 && o_tx_sym4 === 1'b0, "transmit error");
    i_symbol_mode = 1'b1;
    repeat (10) @(negedge i_clk_sys);
    chk(o_tx_sym4 === 1'b1 && o_tx_err === 1'b0, "transmit fifth bit");
  endtask : t_rmii
  initial begin
    t_straps(4'hd, 1'b0, 1'b0);
    t_straps(4'ha, 1'b1, 1'b0);
    t_straps(4'hf, 1'b0, 1'b0);
    t_stream(1'b0);
    t_stream(1'b1);
    @(negedge i_clk_sys);
    i_irq_req = 1'b1;
    @(negedge i_clk_sys);
    chk(o_irq_oe === 1'b1 && o_tx_err === 1'b0, "interrupt output");
    i_irq_req = 1'b0;
    t_rmii();
    close_out();
  end
endmodule : mrxs_top_test
